// ===== src/ast_device.sv
// Device end: asynchronous serial transmitter and receiver with its registers
`timescale 1ns/100ps
`include "ast_regs.svh"

// Summary of operation
// - Clocked-mode bit clear selects asynchronous operation
// - Frame is start, eight/nine data, stop
// - Data bits go least significant first
// - Transmitter, receiver independent; shared format and rate
// - Generator gives x16 or x64 oversampling
// - No hardware parity; ninth bit carries it
// - Polarity bits invert transmit and receive lines
// - Shifter reloads only after stop bit sent
// - Reload takes one cycle, sets buffer-empty flag
// - Empty flag ignores enable, not software clearable
// - Empty flag clears second cycle after write
// - Read-only shifter-empty bit, no interrupt
// - Setting transmit enable sets empty flag
// - Buffer write starts sending; ninth bit preloaded
// - Software configures everything before transmit enable
// - Sixteen-times sampling feeds bit-rate receive shifter
// - Completed character sets flag; enable gates interrupt
// - Status shows ninth bit, errors; read first
// - Clearing continuous receive clears overrun error
// - Nine-bit enable widens; continuous enable starts reception
// - Software sets global and peripheral interrupt enables
// - Reading receive buffer clears receive-complete flag
module ast_device (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Register port toward software
	ast_if.dev bus,
	// Serial lines
	input wire logic rx_i,
	output logic tx_o
);
	logic [7:0] tx_ctl, rx_ctl, baud_ctl, div_hi, div_lo, irq_en, irq_prio;
	logic [15:0] brg_cnt;
	logic [1:0] pre_cnt;
	logic port_on, brg_tick, samp_tick;
	logic [7:0] transmit_buffer;
	logic buf_ninth, buf_full, tx_load, tx_buf_wr;
	logic [10:0] transmit_shift_register;
	logic tx_busy;
	logic [3:0] tx_tick_cnt, tx_bits_left;
	logic transmit_buffer_empty_flag, transmit_enable_q;
	logic [1:0] settle_pipe;
	logic rx_s1, rx_s2, rx_level, rx_run, rx_end, rx_stop_ok, rd_rx_buf;
	ast_pkg::ast_rx_state_e rx_state;
	logic [3:0] rx_cnt, rx_bits, rx_last;
	logic [8:0] rx_sh;
	logic [7:0] receive_buffer, read_val;
	logic received_ninth_bit, framing_error_flag, overrun_error_flag;
	logic receive_complete_flag;

	// Write strobe for one register
	function automatic logic wr_at(input logic wr, input ast_pkg::ast_addr_t a,
		input ast_pkg::ast_addr_t ofs);
		wr_at = wr && (a == ofs);
	endfunction : wr_at

	////////////////////////////////////////////////////////////////////////////
	// Software-written configuration
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			tx_ctl <= `AST_REG_RESET;
			rx_ctl <= `AST_REG_RESET;
			baud_ctl <= `AST_REG_RESET;
			div_hi <= `AST_REG_RESET;
			div_lo <= `AST_REG_RESET;
			irq_en <= `AST_REG_RESET;
			irq_prio <= `AST_REG_RESET;
		end
		else
		begin
			if (wr_at(bus.wr, bus.addr, `AST_TX_STAT_OFS))
				tx_ctl <= bus.wdata & `AST_TX_STAT_WMASK;
			if (wr_at(bus.wr, bus.addr, `AST_RX_STAT_OFS))
				rx_ctl <= bus.wdata & `AST_RX_STAT_WMASK;
			if (wr_at(bus.wr, bus.addr, `AST_BAUD_CTL_OFS))
				baud_ctl <= bus.wdata & `AST_BAUD_CTL_WMASK;
			if (wr_at(bus.wr, bus.addr, `AST_DIV_HI_OFS))
				div_hi <= bus.wdata;
			if (wr_at(bus.wr, bus.addr, `AST_DIV_LO_OFS))
				div_lo <= bus.wdata;
			if (wr_at(bus.wr, bus.addr, `AST_ENABLES_OFS))
				irq_en <= bus.wdata;
			if (wr_at(bus.wr, bus.addr, `AST_PRIORITY_OFS))
				irq_prio <= bus.wdata;
		end
	end

	// Port runs only when enabled and not in clocked mode
	assign port_on = rx_ctl[`AST_PORT_EN_BIT] && !tx_ctl[`AST_CLOCKED_MODE_BIT];

	////////////////////////////////////////////////////////////////////////////
	// Shared baud generator: one rate for both directions
	assign brg_tick = port_on && (brg_cnt == 16'h0000);
	// Slow mode with wide baud clear divides by four more, giving the x64 ratio
	assign samp_tick = brg_tick && ((tx_ctl[`AST_HIGH_SPEED_BIT] || baud_ctl[`AST_WIDE_BAUD_BIT])
		|| (pre_cnt == `AST_PRESCALE_LAST));

	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
			brg_cnt <= 16'h0000;
		else if (!port_on || brg_cnt == 16'h0000)
			brg_cnt <= baud_ctl[`AST_WIDE_BAUD_BIT] ? {div_hi, div_lo} : {8'h00, div_lo};
		else
			brg_cnt <= brg_cnt - 16'h0001;
	end

	// Prescaler for the x64 case
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i || !port_on)
			pre_cnt <= 2'h0;
		else if (brg_tick)
			pre_cnt <= pre_cnt + 2'h1;
	end

	////////////////////////////////////////////////////////////////////////////
	// Transmit buffer; the ninth bit is captured with the byte
	assign tx_buf_wr = wr_at(bus.wr, bus.addr, `AST_TX_BUF_OFS);
	assign tx_load = !tx_busy && buf_full && tx_ctl[`AST_TX_EN_BIT] && port_on;

	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			transmit_buffer <= 8'h00;
			buf_ninth <= 1'b0;
			buf_full <= 1'b0;
		end
		else if (tx_buf_wr)
		begin
			transmit_buffer <= bus.wdata;
			buf_ninth <= tx_ctl[`AST_TX_NINTH_BIT];
			buf_full <= 1'b1;
		end
		else if (tx_load)
			buf_full <= 1'b0;
	end

	// Shift register: start, data, ninth or stop, stop
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i || !port_on)
		begin
			transmit_shift_register <= `AST_SHIFT_IDLE;
			tx_busy <= 1'b0;
			tx_tick_cnt <= 4'h0;
			tx_bits_left <= 4'h0;
		end
		else if (tx_load)
		begin
			transmit_shift_register <= {1'b1, tx_ctl[`AST_TX_NINE_EN_BIT] ? buf_ninth : 1'b1,
				transmit_buffer, 1'b0};
			tx_busy <= 1'b1;
			tx_tick_cnt <= 4'h0;
			tx_bits_left <= tx_ctl[`AST_TX_NINE_EN_BIT] ? `AST_FRAME_LAST_9 : `AST_FRAME_LAST_8;
		end
		else if (tx_busy && samp_tick)
		begin
			tx_tick_cnt <= tx_tick_cnt + 4'h1;
			if (tx_tick_cnt == `AST_BIT_LAST)
			begin
				if (tx_bits_left == 4'h0)
					tx_busy <= 1'b0;
				else
				begin
					transmit_shift_register <= {1'b1, transmit_shift_register[10:1]};
					tx_bits_left <= tx_bits_left - 4'h1;
				end
			end
		end
	end

	// Line idles at mark; polarity applied last
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
			tx_o <= 1'b1;
		else
			tx_o <= (tx_busy ? transmit_shift_register[0] : 1'b1) ^ baud_ctl[`AST_TX_INV_BIT];
	end

	// Buffer-empty flag: hardware only, set wins over the delayed clear
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			transmit_buffer_empty_flag <= 1'b0;
			settle_pipe <= 2'h0;
			transmit_enable_q <= 1'b0;
		end
		else
		begin
			settle_pipe <= {settle_pipe[0], tx_buf_wr};
			transmit_enable_q <= tx_ctl[`AST_TX_EN_BIT];
			if (tx_load || (tx_ctl[`AST_TX_EN_BIT] && !transmit_enable_q))
				transmit_buffer_empty_flag <= 1'b1;
			else if (settle_pipe[1] && buf_full)
				transmit_buffer_empty_flag <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Receive line synchroniser
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			rx_s1 <= 1'b1;
			rx_s2 <= 1'b1;
		end
		else
		begin
			rx_s1 <= rx_i;
			rx_s2 <= rx_s1;
		end
	end

	assign rx_level = rx_s2 ^ baud_ctl[`AST_RX_INV_BIT];
	// An overrun holds off reception until software drops continuous receive
	assign rx_run = port_on && rx_ctl[`AST_CONT_RX_BIT] && !overrun_error_flag;
	assign rx_last = rx_ctl[`AST_RX_NINE_EN_BIT] ? `AST_DATA_LAST_9 : `AST_DATA_LAST_8;

	// Sampling at x16: confirm start at mid-bit, then one sample per bit
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i || !rx_run)
		begin
			rx_state <= ast_pkg::RX_IDLE;
			rx_cnt <= 4'h0;
			rx_bits <= 4'h0;
			rx_sh <= 9'h000;
			rx_end <= 1'b0;
			rx_stop_ok <= 1'b1;
		end
		else
		begin
			rx_end <= 1'b0;
			unique case (rx_state)
				ast_pkg::RX_IDLE:
					if (!rx_level)
					begin
						rx_state <= ast_pkg::RX_START;
						rx_cnt <= 4'h0;
					end
				ast_pkg::RX_START:
					if (samp_tick)
					begin
						rx_cnt <= rx_cnt + 4'h1;
						if (rx_cnt == `AST_START_MID)
						begin
							// Glitch shorter than half a bit is dropped
							rx_state <= rx_level ? ast_pkg::RX_IDLE : ast_pkg::RX_DATA;
							rx_cnt <= 4'h0;
							rx_bits <= 4'h0;
						end
					end
				ast_pkg::RX_DATA:
					if (samp_tick)
					begin
						rx_cnt <= rx_cnt + 4'h1;
						if (rx_cnt == `AST_BIT_LAST)
						begin
							rx_sh <= {rx_level, rx_sh[8:1]};
							rx_bits <= rx_bits + 4'h1;
							if (rx_bits == rx_last)
								rx_state <= ast_pkg::RX_STOP;
						end
					end
				ast_pkg::RX_STOP:
					if (samp_tick)
					begin
						rx_cnt <= rx_cnt + 4'h1;
						if (rx_cnt == `AST_BIT_LAST)
						begin
							rx_state <= ast_pkg::RX_IDLE;
							rx_end <= 1'b1;
							rx_stop_ok <= rx_level;
						end
					end
			endcase
		end
	end

	// Receive buffer and status; a read in the same cycle frees the buffer
	assign rd_rx_buf = bus.rd && (bus.addr == `AST_RX_BUF_OFS);

	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			receive_buffer <= 8'h00;
			received_ninth_bit <= 1'b0;
			framing_error_flag <= 1'b0;
			overrun_error_flag <= 1'b0;
			receive_complete_flag <= 1'b0;
		end
		else
		begin
			if (!rx_ctl[`AST_CONT_RX_BIT])
				overrun_error_flag <= 1'b0;
			if (rd_rx_buf)
				receive_complete_flag <= 1'b0;
			if (rx_end)
			begin
				if (receive_complete_flag && !rd_rx_buf)
					overrun_error_flag <= 1'b1;
				else
				begin
					receive_buffer <= rx_ctl[`AST_RX_NINE_EN_BIT] ? rx_sh[7:0] : rx_sh[8:1];
					received_ninth_bit <= rx_ctl[`AST_RX_NINE_EN_BIT] && rx_sh[8];
					framing_error_flag <= !rx_stop_ok;
					receive_complete_flag <= 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read multiplexer; unmapped offsets read zero
	always_comb
	begin
		read_val = 8'h00;
		case (bus.addr)
			`AST_FLAGS_OFS:
			begin
				read_val[`AST_RX_DONE_BIT] = receive_complete_flag;
				read_val[`AST_TX_EMPTY_BIT] = transmit_buffer_empty_flag;
			end
			`AST_ENABLES_OFS: read_val = irq_en;
			`AST_PRIORITY_OFS: read_val = irq_prio;
			`AST_RX_STAT_OFS:
			begin
				read_val = rx_ctl;
				read_val[`AST_FRAME_ERR_BIT] = framing_error_flag;
				read_val[`AST_OVERRUN_BIT] = overrun_error_flag;
				read_val[`AST_RX_NINTH_BIT] = received_ninth_bit;
			end
			`AST_TX_BUF_OFS: read_val = transmit_buffer;
			`AST_RX_BUF_OFS: read_val = receive_buffer;
			`AST_TX_STAT_OFS:
			begin
				read_val = tx_ctl;
				read_val[`AST_SHIFT_EMPTY_BIT] = !tx_busy;
			end
			`AST_BAUD_CTL_OFS: read_val = baud_ctl;
			`AST_DIV_HI_OFS: read_val = div_hi;
			`AST_DIV_LO_OFS: read_val = div_lo;
			default: read_val = 8'h00;
		endcase
	end

	// Read data held until the next read; request gated by enables only
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			bus.rdata <= 8'h00;
			bus.irq <= 1'b0;
		end
		else
		begin
			if (bus.rd)
				bus.rdata <= read_val;
			bus.irq <= (transmit_buffer_empty_flag && irq_en[`AST_TX_EMPTY_BIT])
				|| (receive_complete_flag && irq_en[`AST_RX_DONE_BIT]);
		end
	end
endmodule : ast_device

// ===== src/ast_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module ast_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Filling side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// Draining side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic [AW:0] next_count;
	logic push;
	logic pop;

	// Wraps at any depth, not only powers of two
	function automatic logic [AW-1:0] ptr_step(input logic [AW-1:0] p);
		ptr_step = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction : ptr_step

	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	assign out_data_o = mem[rd_ptr];

	// Occupancy after this edge
	always_comb
	begin
		next_count = count;
		if (push && !pop)
			next_count = count + 1'b1;
		else if (!push && pop)
			next_count = count - 1'b1;
	end

	// Storage, no reset needed
	always_ff @(posedge clk_i)
	begin
		if (push)
			mem[wr_ptr] <= in_data_i;
	end

	// Pointers and registered full/empty, so both handshakes come from flops
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			in_ready_o <= 1'b1;
			out_valid_o <= 1'b0;
		end
		else
		begin
			if (push)
				wr_ptr <= ptr_step(wr_ptr);
			if (pop)
				rd_ptr <= ptr_step(rd_ptr);
			count <= next_count;
			in_ready_o <= next_count != (AW+1)'(DEPTH);
			out_valid_o <= next_count != '0;
		end
	end
endmodule : ast_fifo

// ===== src/ast_host.sv
// Software-side end: configures the transceiver, feeds it bytes, drains received ones
`timescale 1ns/100ps
`include "ast_regs.svh"
module ast_host #(
	parameter logic [15:0] DIVISOR = 16'h0019,
	parameter logic HIGH_SPEED = 1'b1,
	parameter logic WIDE = 1'b0,
	parameter logic NINE_BIT = 1'b0,
	parameter logic TX_INVERT = 1'b0,
	parameter logic RX_INVERT = 1'b0,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Register port toward the transceiver
	ast_if.host bus,
	// Characters to send
	input wire logic send_valid_i,
	input wire logic [8:0] send_data_i,
	output logic send_ready_o,
	// Characters received
	output logic recv_valid_o,
	output logic [8:0] recv_data_o,
	output logic recv_error_o
);
	ast_pkg::ast_host_state_e state, ret;
	logic [2:0] step, hold;
	logic [7:0] core_interrupt_control, rx_stat_seen;
	logic irq_gated, fifo_valid, fifo_pop;
	logic [8:0] fifo_data;

	// Transmit control value; clocked-mode bit always left clear
	function automatic logic [7:0] tx_word(input logic ninth, input logic en);
		tx_word = 8'h00;
		tx_word[`AST_HIGH_SPEED_BIT] = HIGH_SPEED;
		tx_word[`AST_TX_NINE_EN_BIT] = NINE_BIT;
		tx_word[`AST_TX_NINTH_BIT] = ninth;
		tx_word[`AST_TX_EN_BIT] = en;
	endfunction : tx_word

	// Receive control value
	function automatic logic [7:0] rx_word(input logic cont);
		rx_word = 8'h00;
		rx_word[`AST_PORT_EN_BIT] = 1'b1;
		rx_word[`AST_RX_NINE_EN_BIT] = NINE_BIT;
		rx_word[`AST_CONT_RX_BIT] = cont;
	endfunction : rx_word

	// Setup sequence: rate, polarity, format, port, enables, then transmit enable
	function automatic logic [11:0] cfg_word(input logic [2:0] s);
		logic [7:0] b;
		b = 8'h00;
		b[`AST_TX_INV_BIT] = TX_INVERT;
		b[`AST_RX_INV_BIT] = RX_INVERT;
		b[`AST_WIDE_BAUD_BIT] = WIDE;
		unique case (s)
			3'h0: cfg_word = {`AST_DIV_HI_OFS, DIVISOR[15:8]};
			3'h1: cfg_word = {`AST_DIV_LO_OFS, DIVISOR[7:0]};
			3'h2: cfg_word = {`AST_BAUD_CTL_OFS, b};
			3'h3: cfg_word = {`AST_TX_STAT_OFS, tx_word(1'b0, 1'b0)};
			3'h4: cfg_word = {`AST_RX_STAT_OFS, rx_word(1'b1)};
			3'h5: cfg_word = {`AST_ENABLES_OFS, 8'h30};
			default: cfg_word = {`AST_TX_STAT_OFS, tx_word(1'b0, 1'b1)};
		endcase
	endfunction : cfg_word

	////////////////////////////////////////////////////////////////////////////
	// Send queue; its ready is the user's back-pressure
	assign fifo_pop = (state == ast_pkg::H_TXDATA);

	ast_fifo #(.WIDTH(9), .DEPTH(DEPTH)) u_fifo (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.in_valid_i(send_valid_i),
		.in_ready_o(send_ready_o),
		.in_data_i(send_data_i),
		.out_valid_o(fifo_valid),
		.out_ready_i(fifo_pop),
		.out_data_o(fifo_data)
	);

	// Request reaches the sequencer only with both core enables set
	assign irq_gated = bus.irq && core_interrupt_control[`AST_GLOBAL_IE_BIT]
		&& core_interrupt_control[`AST_PERIPH_IE_BIT];

	////////////////////////////////////////////////////////////////////////////
	// Sequencer; read data is valid two edges after the read strobe
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			state <= ast_pkg::H_CFG;
			ret <= ast_pkg::H_IDLE;
			step <= 3'h0;
			hold <= 3'h0;
			core_interrupt_control <= `AST_REG_RESET;
			rx_stat_seen <= 8'h00;
			bus.addr <= 4'h0;
			bus.wr <= 1'b0;
			bus.rd <= 1'b0;
			bus.wdata <= 8'h00;
			recv_valid_o <= 1'b0;
			recv_data_o <= 9'h000;
			recv_error_o <= 1'b0;
		end
		else
		begin
			bus.wr <= 1'b0;
			bus.rd <= 1'b0;
			recv_valid_o <= 1'b0;
			unique case (state)
				ast_pkg::H_CFG:
				begin
					{bus.addr, bus.wdata} <= cfg_word(step);
					bus.wr <= 1'b1;
					step <= step + 3'h1;
					if (step == `AST_CFG_LAST)
					begin
						core_interrupt_control[`AST_GLOBAL_IE_BIT] <= 1'b1;
						core_interrupt_control[`AST_PERIPH_IE_BIT] <= 1'b1;
						state <= ast_pkg::H_IDLE;
					end
				end
				ast_pkg::H_IDLE:
					if (irq_gated)
					begin
						bus.addr <= `AST_FLAGS_OFS;
						bus.rd <= 1'b1;
						ret <= ast_pkg::H_FLAGS;
						state <= ast_pkg::H_WAIT;
					end
				ast_pkg::H_WAIT: state <= ret;
				ast_pkg::H_FLAGS:
					if (bus.rdata[`AST_RX_DONE_BIT])
					begin
						bus.addr <= `AST_RX_STAT_OFS;
						bus.rd <= 1'b1;
						ret <= ast_pkg::H_STAT;
						state <= ast_pkg::H_WAIT;
					end
					else if (bus.rdata[`AST_TX_EMPTY_BIT] && fifo_valid)
					begin
						bus.addr <= `AST_TX_STAT_OFS;
						bus.wdata <= tx_word(fifo_data[8], 1'b1);
						bus.wr <= 1'b1;
						state <= ast_pkg::H_TXDATA;
					end
					else
						state <= ast_pkg::H_IDLE;
				ast_pkg::H_STAT:
				begin
					rx_stat_seen <= bus.rdata;
					bus.addr <= `AST_RX_BUF_OFS;
					bus.rd <= 1'b1;
					ret <= ast_pkg::H_DATA;
					state <= ast_pkg::H_WAIT;
				end
				ast_pkg::H_DATA:
				begin
					recv_valid_o <= 1'b1;
					recv_data_o <= {rx_stat_seen[`AST_RX_NINTH_BIT], bus.rdata};
					recv_error_o <= rx_stat_seen[`AST_FRAME_ERR_BIT]
						|| rx_stat_seen[`AST_OVERRUN_BIT];
					state <= ast_pkg::H_IDLE;
					if (rx_stat_seen[`AST_FRAME_ERR_BIT] || rx_stat_seen[`AST_OVERRUN_BIT])
					begin
						bus.addr <= `AST_RX_STAT_OFS;
						bus.wdata <= rx_word(1'b0);
						bus.wr <= 1'b1;
						state <= ast_pkg::H_ERR_ON;
					end
				end
				ast_pkg::H_ERR_ON:
				begin
					bus.addr <= `AST_RX_STAT_OFS;
					bus.wdata <= rx_word(1'b1);
					bus.wr <= 1'b1;
					state <= ast_pkg::H_IDLE;
				end
				ast_pkg::H_TXDATA:
				begin
					bus.addr <= `AST_TX_BUF_OFS;
					bus.wdata <= fifo_data[7:0];
					bus.wr <= 1'b1;
					hold <= `AST_HOST_HOLD;
					state <= ast_pkg::H_HOLD;
				end
				ast_pkg::H_HOLD:
				begin
					// Empty flag and request are stale right after a buffer write
					hold <= hold - 3'h1;
					if (hold == 3'h0)
						state <= ast_pkg::H_IDLE;
				end
			endcase
		end
	end
endmodule : ast_host

// ===== src/ast_if.sv
// Register port joining the software side and the transceiver
`timescale 1ns/100ps
interface ast_if;
	ast_pkg::ast_addr_t addr;
	logic wr;
	logic rd;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic irq;

	modport dev (input addr, input wr, input rd, input wdata, output rdata, output irq);
	modport host (output addr, output wr, output rd, output wdata, input rdata, input irq);
endinterface : ast_if

// ===== src/ast_pkg.sv
// Types shared by both ends of the asynchronous serial transceiver
package ast_pkg;

	typedef logic [3:0] ast_addr_t;

	// Receiver sequence
	typedef enum logic [1:0] {
		RX_IDLE,
		RX_START,
		RX_DATA,
		RX_STOP
	} ast_rx_state_e;

	// Software-side sequencer
	typedef enum logic [3:0] {
		H_CFG,
		H_IDLE,
		H_WAIT,
		H_FLAGS,
		H_STAT,
		H_DATA,
		H_ERR_ON,
		H_TXDATA,
		H_HOLD
	} ast_host_state_e;

endpackage : ast_pkg

// ===== src/ast_regs.svh
// Register offsets, field positions, reset values and timing counts of the transceiver
`ifndef AST_REGS_SVH
`define AST_REGS_SVH

////////////////////////////////////////////////////////////////////////////////
// Register offsets on the register port
`define AST_FLAGS_OFS 4'h0
`define AST_ENABLES_OFS 4'h1
`define AST_PRIORITY_OFS 4'h2
`define AST_RX_STAT_OFS 4'h3
`define AST_TX_BUF_OFS 4'h4
`define AST_RX_BUF_OFS 4'h5
`define AST_TX_STAT_OFS 4'h6
`define AST_BAUD_CTL_OFS 4'h7
`define AST_DIV_HI_OFS 4'h8
`define AST_DIV_LO_OFS 4'h9

////////////////////////////////////////////////////////////////////////////////
// Transmit status/control fields
`define AST_TX_NINE_EN_BIT 6
`define AST_TX_EN_BIT 5
`define AST_CLOCKED_MODE_BIT 4
`define AST_HIGH_SPEED_BIT 2
`define AST_SHIFT_EMPTY_BIT 1
`define AST_TX_NINTH_BIT 0
`define AST_TX_STAT_WMASK 8'h75
// Receive status/control fields
`define AST_PORT_EN_BIT 7
`define AST_RX_NINE_EN_BIT 6
`define AST_CONT_RX_BIT 4
`define AST_FRAME_ERR_BIT 2
`define AST_OVERRUN_BIT 1
`define AST_RX_NINTH_BIT 0
`define AST_RX_STAT_WMASK 8'hd0
// Baud control fields
`define AST_RX_INV_BIT 5
`define AST_TX_INV_BIT 4
`define AST_WIDE_BAUD_BIT 3
`define AST_BAUD_CTL_WMASK 8'h38
// Peripheral flag and enable fields
`define AST_RX_DONE_BIT 5
`define AST_TX_EMPTY_BIT 4
// Core interrupt control fields
`define AST_GLOBAL_IE_BIT 7
`define AST_PERIPH_IE_BIT 6

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define AST_REG_RESET 8'h00
`define AST_SHIFT_IDLE 11'h7ff

////////////////////////////////////////////////////////////////////////////////
// Timing counts, in clock cycles, baud ticks, sample ticks or bits
`define AST_PRESCALE_LAST 2'h3
`define AST_START_MID 4'h7
`define AST_BIT_LAST 4'hf
`define AST_FRAME_LAST_8 4'h9
`define AST_FRAME_LAST_9 4'ha
`define AST_DATA_LAST_8 4'h7
`define AST_DATA_LAST_9 4'h8
`define AST_HOST_HOLD 3'h4
`define AST_CFG_LAST 3'h6

`endif

// ===== tb/ast_link_props.sv
// Checker of the register port and serial line between the two ends
`timescale 1ns/100ps
module ast_link_props (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Register port and line
	input wire ast_pkg::ast_addr_t addr,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic irq,
	input wire logic tx_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);
	////////////////////////////////////////////////////////////////////////////////
	// Error seen in a status read, then receive switched off
	sequence s_err;
		rd && addr == 4'h3 ##1 (rdata[2] || rdata[1]);
	endsequence
	sequence s_rx_off;
		wr && addr == 4'h3 && !wdata[4];
	endsequence
	////////////////////////////////////////////////////////////////////////////////
	AST_RDATA_HOLD:
	assert property (rdata != $past(rdata) |-> $past(rd))
		else $error("read data moved");
	AST_ASYNC_MODE:
	assert property (wr && addr == 4'h6 |-> !wdata[4])
		else $error("clocked mode set");
	AST_TX_EN_SETUP:
	assert property ($rose(rst_b_i) |-> ##[0:8] (wr && addr == 4'h6 && wdata[5]))
		else $error("no transmit enable");
	AST_LOW_BIT:
	assert property ($fell(tx_o) |-> (!tx_o) [*8] ##1 (!tx_o) [*8])
		else $error("short low bit");
	AST_HIGH_BIT:
	assert property ($rose(tx_o) |-> tx_o [*8] ##1 tx_o [*8])
		else $error("short high bit");
	AST_STAT_DATA:
	assert property (rd && addr == 4'h3 |-> ##[1:8] (rd && addr == 4'h5))
		else $error("no data read");
	AST_ERR_CLEAR:
	assert property (s_err |-> ##[0:16] s_rx_off)
		else $error("error not cleared");
	AST_IRQ_SERVED:
	assert property ($rose(irq) |-> ##[0:16] (rd && addr == 4'h0))
		else $error("irq not served");
endmodule : ast_link_props

// ===== tb/tb_async_serial_transceiver.sv
// Loop-back testbench joining the software-side end and the transceiver
`timescale 1ns/100ps
module tb_async_serial_transceiver;
	logic clk_i;
	logic rst_b_i = 1'b0;
	logic send_valid_i = 1'b0;
	logic [8:0] send_data_i = 9'h000;
	logic send_ready_o;
	logic recv_valid_o;
	logic [8:0] recv_data_o;
	logic recv_error_o;
	logic tx_o;
	logic line_ok = 1'b1;
	logic full_seen = 1'b0;
	logic [9:0] frame;
	logic valid_b = 1'b0;
	logic tx_b;
	logic recv_valid_b;
	logic [8:0] recv_data_b;
	int bad_count = 0;
	int n_tests = 0;
	// Character offered beside the byte that must return
	logic [16:0] rows [6] = '{17'h05555, 17'h0ffff, 17'h00000, 17'h0a3a3, 17'h00101, 17'h18080};
	////////////////////////////////////////////////////////////////////////////////
	ast_if i_ast_if ();
	ast_device i_ast_device (.clk_i(clk_i), .rst_b_i(rst_b_i), .bus(i_ast_if),
		.rx_i(tx_o & line_ok), .tx_o(tx_o));
	ast_host #(.DIVISOR(16'h0000)) i_ast_host (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.bus(i_ast_if), .send_valid_i(send_valid_i), .send_data_i(send_data_i),
		.send_ready_o(send_ready_o), .recv_valid_o(recv_valid_o),
		.recv_data_o(recv_data_o), .recv_error_o(recv_error_o));
	ast_link_props i_ast_link_props (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr(i_ast_if.addr),
		.wr(i_ast_if.wr), .rd(i_ast_if.rd), .wdata(i_ast_if.wdata),
		.rdata(i_ast_if.rdata), .irq(i_ast_if.irq), .tx_o(tx_o));
	// Second pair: x64 rate, nine bits, both lines inverted
	ast_if i_ast_if_b ();
	ast_device i_ast_device_b (.clk_i(clk_i), .rst_b_i(rst_b_i), .bus(i_ast_if_b),
		.rx_i(tx_b), .tx_o(tx_b));
	ast_host #(.DIVISOR(16'h0000), .HIGH_SPEED(1'b0), .NINE_BIT(1'b1), .TX_INVERT(1'b1),
		.RX_INVERT(1'b1)) i_ast_host_b (.clk_i(clk_i), .rst_b_i(rst_b_i), .bus(i_ast_if_b),
		.send_valid_i(valid_b), .send_data_i(9'h1a5), .send_ready_o(),
		.recv_valid_o(recv_valid_b), .recv_data_o(recv_data_b), .recv_error_o());
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : check
	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict
	// Offer one character; valid stays up between calls
	task automatic send(input logic [8:0] d);
		send_valid_i <= 1'b1;
		send_data_i <= d;
		do @(posedge clk_i); while (send_ready_o !== 1'b1);
	endtask : send
	// Bounded wait so a lost character cannot hang the run
	task automatic expect_char(input logic [7:0] exp, input logic err);
		int k;
		k = 0;
		@(posedge clk_i);
		while (recv_valid_o !== 1'b1 && k++ < 3000)
			@(posedge clk_i);
		check("valid", 10'(recv_valid_o), 10'h001);
		check("data", 10'(recv_data_o), 10'(exp));
		check("error", 10'(recv_error_o), 10'(err));
	endtask : expect_char
	////////////////////////////////////////////////////////////////////////////////
	// Clock
	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// Watchdog, far beyond the fourteen hundred or so cycles needed
	initial
	begin
		repeat (30000) @(posedge clk_i);
		bad_count++;
		print_verdict();
	end
	// Refusal seen while the far side is still shifting
	always @(posedge clk_i)
		if (send_valid_i && send_ready_o === 1'b0)
			full_seen <= 1'b1;
	// Main sequence
	initial
	begin
		repeat (12) @(posedge clk_i);
		check("idle", 10'(tx_o), 10'h001);
		rst_b_i <= 1'b1;
		fork
			begin
				foreach (rows[i])
					send(rows[i][16:8]);
				send_valid_i <= 1'b0;
			end
			foreach (rows[i])
				expect_char(rows[i][7:0], 1'b0);
			begin
				valid_b <= 1'b1;
				@(posedge clk_i);
				valid_b <= 1'b0;
				while (recv_valid_b !== 1'b1)
					@(posedge clk_i);
				check("nine", 10'(recv_data_b), 10'h1a5);
			end
			begin
				@(posedge clk_i);
				while (tx_o !== 1'b0)
					@(posedge clk_i);
				repeat (8) @(posedge clk_i);
				for (int k = 0; k < 10; k++)
				begin
					frame[k] = tx_o;
					repeat (16) @(posedge clk_i);
				end
			end
		join
		check("frame", frame, {1'b1, 8'h55, 1'b0});
		check("full", 10'(full_seen), 10'h001);
		// Line held low past the stop bit gives a broken zero character
		fork
			begin
				line_ok <= 1'b0;
				repeat (156) @(posedge clk_i);
				line_ok <= 1'b1;
			end
			expect_char(8'h00, 1'b1);
		join
		// Reception resumes once the error is cleared
		fork
			begin
				send(9'h03c);
				send_valid_i <= 1'b0;
			end
			expect_char(8'h3c, 1'b0);
		join
		// Mid-run reset returns the line and the handshakes to idle
		rst_b_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		check("reset", 10'({tx_o, send_ready_o, recv_valid_o, i_ast_if.irq}), 10'h00c);
		print_verdict();
	end
endmodule : tb_async_serial_transceiver
